/* verilog/mlat_table.sv */
// address learning, lookup and aging table
`timescale 1ns/1ns
`default_nettype none
`include "mlat_map.svh"

// Functional notes
// - learn each frame's source address with its vlan and arrival port
// - choose egress port by looking up vlan and destination address
// - no match in the vlan means flood to vlan forwarding members
// - remove dynamic entries unused longer than the aging time in seconds
// - static entries are never aged or deleted
// - aging time defaults to 1800 seconds after reset or restore
// - aging time of zero disables aging
// - aging time accepts values up to 100000 seconds
// - aging scan runs every one seventh of the aging time
// - at most 16 K aging events reported per aging cycle
// - software may install static entries bound to an egress port
// - global mode picks legacy or conversational learning
// - conversational destination aging defaults to 300 seconds
// - learning can be disabled per port and vlan
module mlat_table #(
    parameter int DEPTH      = 16,
    parameter int PORTS      = 8,
    parameter int PW         = 3,
    parameter int TICK_COUNT = `MLAT_SEC_NS / `MLAT_CLK_NS
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // frame header from forwarding pipeline
    input  wire logic              frm_valid,
    input  wire mlat_pkg::mlat_mac_t  frm_src,
    input  wire mlat_pkg::mlat_mac_t  frm_dst,
    input  wire mlat_pkg::mlat_vlan_t frm_vlan,
    input  wire logic [PW-1:0]     frm_port,
    output logic                   frm_ready,
    // forwarding decision
    output logic                   fwd_valid,
    output logic                   fwd_flood,
    output logic [PW-1:0]          fwd_port,
    output mlat_pkg::mlat_vlan_t   fwd_vlan,
    // configuration
    input  wire mlat_pkg::mlat_sec_t  cfg_age_s,
    input  wire logic              cfg_age_default,
    input  wire mlat_pkg::mlat_sec_t  cfg_conv_age_s,
    input  wire logic              cfg_conv_default,
    input  wire logic              conversational_learning_mode,
    input  wire logic [PORTS-1:0]  cfg_learn_off,
    input  wire mlat_pkg::mlat_vlan_t cfg_learn_off_vlan,
    input  wire logic              cfg_learn_off_en,
    // static entry install
    input  wire logic              st_valid,
    input  wire mlat_pkg::mlat_mac_t  st_mac,
    input  wire mlat_pkg::mlat_vlan_t st_vlan,
    input  wire logic [PW-1:0]     st_port,
    output logic                   st_ready,
    // status
    output logic                   age_event,
    output logic [14:0]            age_event_cnt,
    output logic                   table_full
);
    import mlat_pkg::*;

    localparam int IW = $clog2(DEPTH);

    // table storage
    mlat_mac_t  mac_q   [DEPTH];
    mlat_vlan_t vlan_q  [DEPTH];
    logic [PW-1:0] port_q [DEPTH];
    logic [DEPTH-1:0] vld_q;
    logic [DEPTH-1:0] stat_q;
    logic [DEPTH-1:0] conv_q;   // entry learned from a source in conv mode
    mlat_sec_t  idle_q  [DEPTH];

    mlat_state_e st_q;
    mlat_mac_t  src_q, dst_q;
    mlat_vlan_t vl_q;
    logic [PW-1:0] inp_q;
    logic [IW-1:0] scan_idx_q;
    logic [31:0] tick_cnt_q;
    logic        sec_tick;
    mlat_sec_t   age_s_q, conv_s_q, scan_cnt_q, scan_per;
    logic [2:0]  scan_part_q;
    logic        scan_pend_q;
    logic [14:0] evt_cnt_q;

    ////////////////////////////////////////////////////////////////
    // one second tick
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_cnt_q <= 32'h0;
        end else if (tick_cnt_q == 32'(TICK_COUNT - 1)) begin
            tick_cnt_q <= 32'h0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
        end
    end
    assign sec_tick = (tick_cnt_q == 32'(TICK_COUNT - 1));

    ////////////////////////////////////////////////////////////////
    // aging time held, default 1800, clamped at max
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            age_s_q <= `MLAT_AGE_DEFAULT_S;
        end else if (cfg_age_default) begin
            age_s_q <= `MLAT_AGE_DEFAULT_S;
        end else if (cfg_age_s > `MLAT_AGE_MAX_S) begin
            age_s_q <= `MLAT_AGE_MAX_S;
        end else begin
            age_s_q <= cfg_age_s;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            conv_s_q <= `MLAT_CONV_DEFAULT_S;
        end else if (cfg_conv_default) begin
            conv_s_q <= `MLAT_CONV_DEFAULT_S;
        end else if (cfg_conv_age_s > `MLAT_AGE_MAX_S) begin
            conv_s_q <= `MLAT_AGE_MAX_S;
        end else begin
            conv_s_q <= cfg_conv_age_s;
        end
    end

    ////////////////////////////////////////////////////////////////
    // scan period is one seventh of aging time, at least 1 s
    assign scan_per = (age_s_q / `MLAT_SCAN_DIV == 17'h0) ? 17'h1
                                                           : age_s_q / `MLAT_SCAN_DIV;

    // scan scheduler; zero aging time never scans
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scan_cnt_q  <= 17'h0;
            scan_pend_q <= 1'b0;
            scan_part_q <= 3'h0;
        end else begin
            if (st_q == MLAT_SCAN && scan_idx_q == IW'(DEPTH - 1)) begin
                scan_pend_q <= 1'b0;
            end
            if (sec_tick && age_s_q != 17'h0) begin
                if (scan_cnt_q + 17'h1 >= scan_per) begin
                    scan_cnt_q  <= 17'h0;
                    scan_pend_q <= 1'b1;
                    scan_part_q <= (scan_part_q == 3'h6) ? 3'h0 : scan_part_q + 3'h1;
                end else begin
                    scan_cnt_q <= scan_cnt_q + 17'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // free slot and lookup
    logic [IW-1:0] free_idx, src_idx, dst_idx, st_idx;
    logic          free_hit, src_hit, dst_hit, st_hit;
    always_comb begin
        free_idx = '0;
        free_hit = 1'b0;
        src_idx  = '0;
        src_hit  = 1'b0;
        dst_idx  = '0;
        dst_hit  = 1'b0;
        st_idx   = '0;
        st_hit   = 1'b0;
        for (int i = DEPTH - 1; i >= 0; i--) begin
            if (!vld_q[i]) begin
                free_idx = IW'(i);
                free_hit = 1'b1;
            end
            if (vld_q[i] && mac_q[i] == dst_q && vlan_q[i] == vl_q) begin
                dst_idx = IW'(i);
                dst_hit = 1'b1;
            end
            if (vld_q[i] && mac_q[i] == src_q && vlan_q[i] == vl_q) begin
                src_idx = IW'(i);
                src_hit = 1'b1;
            end
            if (vld_q[i] && mac_q[i] == st_mac && vlan_q[i] == st_vlan) begin
                st_idx = IW'(i);
                st_hit = 1'b1;
            end
        end
    end

    // learning blocked for this port and vlan
    logic learn_ok;
    assign learn_ok = !(cfg_learn_off_en && cfg_learn_off[inp_q] && vl_q == cfg_learn_off_vlan);

    assign frm_ready  = (st_q == MLAT_IDLE) && !scan_pend_q;
    assign st_ready   = (st_q == MLAT_IDLE) && !scan_pend_q && !frm_valid;
    assign table_full = &vld_q;

    ////////////////////////////////////////////////////////////////
    // control state machine
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q       <= MLAT_IDLE;
            scan_idx_q <= '0;
            src_q      <= '0;
            dst_q      <= '0;
            vl_q       <= '0;
            inp_q      <= '0;
        end else begin
            case (st_q)
                MLAT_IDLE: begin
                    if (scan_pend_q) begin
                        st_q       <= MLAT_SCAN;
                        scan_idx_q <= '0;
                    end else if (frm_valid) begin
                        src_q <= frm_src;
                        dst_q <= frm_dst;
                        vl_q  <= frm_vlan;
                        inp_q <= frm_port;
                        st_q  <= MLAT_LOOK;
                    end
                end
                MLAT_LOOK:  st_q <= MLAT_WRITE;
                MLAT_WRITE: st_q <= MLAT_IDLE;
                MLAT_SCAN: begin
                    if (scan_idx_q == IW'(DEPTH - 1)) begin
                        st_q <= MLAT_IDLE;
                    end
                    scan_idx_q <= scan_idx_q + IW'(1);
                end
                default: st_q <= MLAT_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // forwarding decision, registered
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fwd_valid <= 1'b0;
            fwd_flood <= 1'b0;
            fwd_port  <= '0;
            fwd_vlan  <= '0;
        end else begin
            fwd_valid <= (st_q == MLAT_LOOK);
            if (st_q == MLAT_LOOK) begin
                fwd_flood <= !dst_hit;
                fwd_port  <= dst_hit ? port_q[dst_idx] : '0;
                fwd_vlan  <= vl_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // entry store: learn, install, age
    logic age_lim;
    logic [2:0] part_of;
    logic [IW-1:0] scan_idx;    // scan position seen by the expiry test
    assign age_lim = (evt_cnt_q < `MLAT_EVT_LIMIT);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vld_q  <= '0;
            stat_q <= '0;
            conv_q <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mac_q[i]  <= '0;
                vlan_q[i] <= '0;
                port_q[i] <= '0;
                idle_q[i] <= '0;
            end
        end else begin
            // idle seconds advance for dynamic entries
            if (sec_tick) begin
                for (int i = 0; i < DEPTH; i++) begin
                    if (vld_q[i] && !stat_q[i] && idle_q[i] != `MLAT_AGE_MAX_S) begin
                        idle_q[i] <= idle_q[i] + 17'h1;
                    end
                end
            end
            if (st_q == MLAT_IDLE && !scan_pend_q && !frm_valid && st_valid) begin
                // static entry install or override, over a live entry only of the same address and vlan
                if (st_hit || free_hit) begin
                    mac_q[st_hit ? st_idx : free_idx]  <= st_mac;
                    vlan_q[st_hit ? st_idx : free_idx] <= st_vlan;
                    port_q[st_hit ? st_idx : free_idx] <= st_port;
                    vld_q[st_hit ? st_idx : free_idx]  <= 1'b1;
                    stat_q[st_hit ? st_idx : free_idx] <= 1'b1;
                    conv_q[st_hit ? st_idx : free_idx] <= 1'b0;
                end
            end
            if (st_q == MLAT_WRITE && learn_ok) begin
                // known dynamic sources refresh in both modes; new sources always in legacy, in conv only when destination known
                if (src_hit && !stat_q[src_idx]) begin
                    port_q[src_idx] <= inp_q;
                    idle_q[src_idx] <= '0;
                end else if (!src_hit && free_hit
                             && (!conversational_learning_mode || dst_hit)) begin
                    mac_q[free_idx]  <= src_q;
                    vlan_q[free_idx] <= vl_q;
                    port_q[free_idx] <= inp_q;
                    vld_q[free_idx]  <= 1'b1;
                    stat_q[free_idx] <= 1'b0;
                    conv_q[free_idx] <= conversational_learning_mode;
                    idle_q[free_idx] <= '0;
                end
                if (conversational_learning_mode && dst_hit && !stat_q[dst_idx]) begin
                    idle_q[dst_idx] <= '0;
                end
            end
            // expire idle dynamic entries; static skipped
            if (st_q == MLAT_SCAN && vld_q[scan_idx] && !stat_q[scan_idx] && age_lim
                && age_s_q != 17'h0
                && idle_q[scan_idx] >= (conv_q[scan_idx] ? conv_s_q : age_s_q)) begin
                vld_q[scan_idx] <= 1'b0;
            end
        end
    end
    assign scan_idx = scan_idx_q;
    assign part_of  = scan_part_q;

    ////////////////////////////////////////////////////////////////
    // aging event count limited per aging cycle
    logic expire;
    assign expire = (st_q == MLAT_SCAN) && vld_q[scan_idx] && !stat_q[scan_idx] && age_lim
                    && age_s_q != 17'h0
                    && idle_q[scan_idx] >= (conv_q[scan_idx] ? conv_s_q : age_s_q);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            evt_cnt_q <= '0;
            age_event <= 1'b0;
        end else begin
            age_event <= expire;
            if (sec_tick && scan_cnt_q + 17'h1 >= scan_per && part_of == 3'h6) begin
                evt_cnt_q <= '0;
            end else if (expire) begin
                evt_cnt_q <= evt_cnt_q + 15'h1;
            end
        end
    end
    assign age_event_cnt = evt_cnt_q;

endmodule
`default_nettype wire

/* verilog/mlat_map.svh */
// constants for the address learning and aging table
`ifndef MLAT_MAP_SVH
`define MLAT_MAP_SVH
`define MLAT_AGE_DEFAULT_S   17'h00708
`define MLAT_CONV_DEFAULT_S  17'h0012c
`define MLAT_AGE_MAX_S       17'h186a0
`define MLAT_SCAN_DIV        17'h00007
`define MLAT_EVT_LIMIT       15'h4000
`define MLAT_CLK_HZ          100000000
`define MLAT_SEC_NS          1000000000
`define MLAT_CLK_NS          10
`endif

/* verilog/mlat_pkg.sv */
// types for the address learning and aging table
package mlat_pkg;
    typedef logic [47:0] mlat_mac_t;
    typedef logic [11:0] mlat_vlan_t;
    typedef logic [16:0] mlat_sec_t;
    typedef enum logic [3:0] {
        MLAT_IDLE  = 4'h1,
        MLAT_LOOK  = 4'h2,
        MLAT_SCAN  = 4'h4,
        MLAT_WRITE = 4'h8
    } mlat_state_e;
endpackage

/* tb/mlat_table_checker.sv */
// port assertions for the learning table
`timescale 1ns/1ns
`default_nettype none
module mlat_table_checker #(
    parameter int PW = 3
) (
    // clock and reset
    input wire logic                 clk,
    input wire logic                 rst,
    // frame and decision
    input wire logic                 frm_valid,
    input wire mlat_pkg::mlat_vlan_t frm_vlan,
    input wire logic                 frm_ready,
    input wire logic                 fwd_valid,
    input wire logic [PW-1:0]        fwd_port,
    input wire mlat_pkg::mlat_vlan_t fwd_vlan,
    // config and status
    input wire mlat_pkg::mlat_sec_t  cfg_age_s,
    input wire logic                 cfg_age_default,
    input wire logic                 st_ready,
    input wire logic                 age_event,
    input wire logic [14:0]          age_event_cnt
);
    import mlat_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [6:0] off_q;
    // cycles since aging was switched off, saturating
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            off_q <= 7'h00;
        end else if (cfg_age_s != 17'h00000 || cfg_age_default) begin
            off_q <= 7'h00;
        end else if (off_q != 7'h7f) begin
            off_q <= off_q + 7'h01;
        end
    end
    sequence s_taken;
        frm_valid && frm_ready;
    endsequence
    sequence s_busy;
        !frm_ready ##1 !frm_ready;
    endsequence
    a_fwd_two_cycles: assert property (s_taken |-> ##2 fwd_valid)
        else $error("decision late");
    a_busy_after_frame: assert property (s_taken |=> s_busy)
        else $error("ready during learn write");
    a_fwd_vlan_echo: assert property (s_taken |-> ##2 fwd_vlan == $past(frm_vlan, 2))
        else $error("decision vlan differs");
    a_fwd_one_pulse: assert property (fwd_valid |=> !fwd_valid)
        else $error("decision pulse too long");
    a_data_holds: assert property (!fwd_valid |-> $stable(fwd_port) && $stable(fwd_vlan))
        else $error("decision data moved");
    a_static_quiet: assert property (st_ready |=> !fwd_valid)
        else $error("decision after static install");
    a_evt_limit: assert property (age_event_cnt <= 15'h4000)
        else $error("too many aging events");
    a_age_zero_quiet: assert property (off_q == 7'h7f |-> !age_event)
        else $error("removal with aging off");
    a_ready_returns: assert property (!frm_ready |-> ##[1:40] frm_ready)
        else $error("scan holds ready too long");
endmodule
bind mlat_table mlat_table_checker #(.PW(PW)) u_chk (.clk(clk), .rst(rst),
    .frm_valid(frm_valid), .frm_vlan(frm_vlan), .frm_ready(frm_ready),
    .fwd_valid(fwd_valid), .fwd_port(fwd_port), .fwd_vlan(fwd_vlan),
    .cfg_age_s(cfg_age_s), .cfg_age_default(cfg_age_default), .st_ready(st_ready),
    .age_event(age_event), .age_event_cnt(age_event_cnt));
`default_nettype wire

/* tb/mlat_pipe_model.sv */
// forwarding pipeline model presenting frame headers
`timescale 1ns/1ns
`default_nettype none
module mlat_pipe_model #(
    parameter int PW = 3
) (
    // clock and decision
    input  wire logic                 clk,
    input  wire logic                 frm_ready,
    input  wire logic                 fwd_valid,
    input  wire logic                 fwd_flood,
    input  wire logic [PW-1:0]        fwd_port,
    input  wire mlat_pkg::mlat_vlan_t fwd_vlan,
    // frame header
    output logic                      frm_valid,
    output mlat_pkg::mlat_mac_t       frm_src,
    output mlat_pkg::mlat_mac_t       frm_dst,
    output mlat_pkg::mlat_vlan_t      frm_vlan,
    output logic [PW-1:0]             frm_port
);
    import mlat_pkg::*;
    // idle header at time zero
    initial begin
        frm_valid = 1'b0;
        frm_src = '0;
        frm_dst = '0;
        frm_vlan = '0;
        frm_port = '0;
    end
    // hold one header until taken, then wait for its decision
    task automatic send(input mlat_mac_t s, input mlat_mac_t d, input mlat_vlan_t v,
        input logic [PW-1:0] p, output logic fl, output logic [PW-1:0] op,
        output mlat_vlan_t ov);
        int n;
        fl = 1'bx;
        op = 'x;
        ov = 'x;
        @(posedge clk);
        #1;
        frm_valid = 1'b1;
        frm_src = s;
        frm_dst = d;
        frm_vlan = v;
        frm_port = p;
        n = 0;
        while (frm_ready !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        #1;
        frm_valid = 1'b0;
        // released fields show the inverse, not the old header
        frm_src = ~s;
        frm_dst = ~d;
        frm_vlan = ~v;
        frm_port = ~p;
        n = 0;
        while (fwd_valid !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (fwd_valid === 1'b1) begin
            fl = fwd_flood;
            op = fwd_port;
            ov = fwd_vlan;
        end
    endtask
endmodule
`default_nettype wire

/* tb/mlat_table_tb.sv */
// self-checking bench for the learning table
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module mlat_table_tb;
    import mlat_pkg::*;
    localparam mlat_mac_t MA = 48'h001122223333;
    localparam mlat_mac_t MB = 48'h0a0000000002;
    localparam mlat_mac_t UNK = 48'h0e0000000001;
    logic clk = 1'b0, rst = 1'b1, frm_valid, frm_ready, fwd_valid, fwd_flood;
    logic [2:0] frm_port, fwd_port, st_port = 3'h0, p;
    mlat_mac_t frm_src, frm_dst, st_mac = '0, s;
    mlat_vlan_t frm_vlan, fwd_vlan, st_vlan = '0, cfg_learn_off_vlan = '0;
    mlat_sec_t cfg_age_s = 17'h00000, cfg_conv_age_s = 17'h0003c;
    logic cfg_age_default = 1'b1, cfg_conv_default = 1'b1, conv = 1'b0, st_valid = 1'b0;
    logic [7:0] cfg_learn_off = 8'h00;
    logic cfg_learn_off_en = 1'b0, st_ready, age_event, table_full;
    logic [14:0] age_event_cnt;
    int errors = 0, comparisons = 0, cyc = 0, n_evt = 0;
    always #5 clk = ~clk;
    mlat_table #(.DEPTH(16), .PORTS(8), .PW(3), .TICK_COUNT(20)) uut (.clk(clk), .rst(rst),
        .frm_valid(frm_valid), .frm_src(frm_src), .frm_dst(frm_dst), .frm_vlan(frm_vlan),
        .frm_port(frm_port), .frm_ready(frm_ready), .fwd_valid(fwd_valid),
        .fwd_flood(fwd_flood), .fwd_port(fwd_port), .fwd_vlan(fwd_vlan),
        .cfg_age_s(cfg_age_s), .cfg_age_default(cfg_age_default),
        .cfg_conv_age_s(cfg_conv_age_s), .cfg_conv_default(cfg_conv_default),
        .conversational_learning_mode(conv), .cfg_learn_off(cfg_learn_off),
        .cfg_learn_off_vlan(cfg_learn_off_vlan), .cfg_learn_off_en(cfg_learn_off_en),
        .st_valid(st_valid), .st_mac(st_mac), .st_vlan(st_vlan), .st_port(st_port),
        .st_ready(st_ready), .age_event(age_event), .age_event_cnt(age_event_cnt),
        .table_full(table_full));
    mlat_pipe_model #(.PW(3)) pipe (.clk(clk), .frm_ready(frm_ready), .fwd_valid(fwd_valid),
        .fwd_flood(fwd_flood), .fwd_port(fwd_port), .fwd_vlan(fwd_vlan),
        .frm_valid(frm_valid), .frm_src(frm_src), .frm_dst(frm_dst), .frm_vlan(frm_vlan),
        .frm_port(frm_port));
    // verdict and end of run
    task test_done;
        if (errors == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // expected flood flag for a lookup
    function automatic logic exp_flood(input logic hit);
        return !hit;
    endfunction
    // frame from an address onto a never-learned destination
    task automatic learn(input mlat_mac_t m, input mlat_vlan_t v, input logic [2:0] pt);
        logic fl;
        logic [2:0] op;
        mlat_vlan_t ov;
        pipe.send(m, UNK, v, pt, fl, op, ov);
    endtask
    // lookup probe from port 7, checking the decision
    task automatic look(input mlat_mac_t d, input mlat_vlan_t v, input logic hit,
        input logic [2:0] pt);
        logic fl;
        logic [2:0] op;
        mlat_vlan_t ov;
        pipe.send(48'h0c0000000007, d, v, 3'h7, fl, op, ov);
        `CHK(fl, exp_flood(hit))
        `CHK(ov, v)
        if (hit) `CHK(op, pt)
    endtask
    // static install, held until accepted
    task automatic put_static(input mlat_mac_t m, input mlat_vlan_t v, input logic [2:0] pt);
        int k;
        @(posedge clk);
        #1;
        st_valid = 1'b1;
        st_mac = m;
        st_vlan = v;
        st_port = pt;
        k = 0;
        while (st_ready !== 1'b1 && k < 100) begin
            @(posedge clk);
            #1;
            k++;
        end
        if (st_ready !== 1'b1) errors++;
        @(posedge clk);
        #1;
        st_valid = 1'b0;
        st_mac = ~m;
    endtask
    // cycle ceiling and removal count
    always @(posedge clk) begin
        cyc++;
        if (age_event === 1'b1) n_evt++;
        if (cyc == 6000) begin
            errors++;
            test_done();
        end
    end
    // main sequence
    initial begin
        void'($urandom(32'hafa5b522));
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        put_static(MA, 12'h005, 3'h3);
        look(MA, 12'h005, 1'b1, 3'h3);
        look(48'h0a0000000099, 12'h005, 1'b0, 3'h0);
        learn(MB, 12'h005, 3'h2);
        look(MB, 12'h005, 1'b1, 3'h2);
        cfg_learn_off = 8'h10;
        cfg_learn_off_vlan = 12'h005;
        cfg_learn_off_en = 1'b1;
        learn(48'h0a0000000003, 12'h005, 3'h4);
        look(48'h0a0000000003, 12'h005, 1'b0, 3'h0);
        cfg_learn_off_en = 1'b0;
        conv = 1'b1;
        learn(48'h0a0000000005, 12'h005, 3'h1);
        @(posedge clk);
        #1;
        conv = 1'b0;
        look(48'h0a0000000005, 12'h005, 1'b0, 3'h0);
        for (int i = 0; i < 4; i++) begin
            s = {16'h0200, 32'($urandom)};
            p = 3'($urandom_range(6, 0));
            learn(s, 12'h009, p);
            look(s, 12'h009, 1'b1, p);
        end
        `CHK(table_full, 1'b0)
        cfg_age_default = 1'b0;
        repeat (400) @(posedge clk);
        look(MB, 12'h005, 1'b1, 3'h2);
        cfg_age_s = 17'h0000e;
        repeat (800) @(posedge clk);
        look(MB, 12'h005, 1'b0, 3'h0);
        look(MA, 12'h005, 1'b1, 3'h3);
        `CHK(n_evt > 0, 1'b1)
        test_done();
    end
endmodule
`default_nettype wire
